// ### rtl/stl1_consts.svh
`ifndef STL1_CONSTS_SVH
`define STL1_CONSTS_SVH

// ****************************************
// Command codes
// ****************************************
`define STL1_CMD_DEACT_REQ 4'h0
`define STL1_CMD_CLEAR 4'h1
`define STL1_CMD_SINGLE_PULSE 4'h2
`define STL1_CMD_CONT_PULSE 4'h3
`define STL1_CMD_RX_UNSYNC 4'h4
`define STL1_CMD_ACT_REQ 4'h8
`define STL1_CMD_LOOP_ACT_REQ 4'hA
`define STL1_CMD_ACT_DONE 4'hC
`define STL1_CMD_LOOP_ACT_IND 4'hE
`define STL1_CMD_DEACT_CONFIRM 4'hF

// ****************************************
// Indication codes
// ****************************************
`define STL1_IND_TIMING 4'h0
`define STL1_IND_CLEAR 4'h1
`define STL1_IND_RX_UNSYNC 4'h4
`define STL1_IND_ACT_REQ 4'h8
`define STL1_IND_CODE_VIOL 4'hB
`define STL1_IND_ACT_DONE 4'hC
`define STL1_IND_DEACT_DONE 4'hF

// ****************************************
// Timing
// ****************************************
`define STL1_CLK_HZ 50000000
`define STL1_INFO0_QUIET_MS 16
`define STL1_DEACT_TIMER_MS 32
`define STL1_INFO0_QUIET_CYC ((`STL1_CLK_HZ / 1000) * `STL1_INFO0_QUIET_MS)
`define STL1_DEACT_TIMER_CYC ((`STL1_CLK_HZ / 1000) * `STL1_DEACT_TIMER_MS)

`endif

// ### rtl/stl1_pkg.sv
package stl1_pkg;

  typedef enum logic [3:0] {
    ST_DEACT = 4'h0,
    ST_INFO0_DET = 4'h1,
    ST_PEND_ACT = 4'h3,
    ST_WAIT_SWITCH = 4'h2,
    ST_ACTIVE = 4'h6,
    ST_LOST_ST = 4'h7,
    ST_LOST_UP = 4'h5,
    ST_PEND_DEACT = 4'h4,
    ST_WAIT_CONFIRM = 4'hC,
    ST_CLEARED = 4'hD,
    ST_TEST_SINGLE = 4'hF,
    ST_TEST_CONT = 4'hE
  } stl1_state_t;

  typedef enum logic [2:0] {
    TX_INFO0 = 3'h0,
    TX_INFO2 = 3'h2,
    TX_INFO4 = 3'h4,
    TX_SINGLE = 3'h5,
    TX_CONT = 3'h6
  } stl1_tx_info_t;

  typedef struct packed {
    logic info0;
    logic level;
    logic info3;
    logic sync;
    logic codeViol;
  } stl1_line_rx_t;

  typedef struct packed {
    stl1_tx_info_t txInfo;
    logic loop2Closed;
    logic transparent;
    logic clockStop;
  } stl1_line_ctl_t;

endpackage

// ### rtl/stl1_cmd_latch.sv
`timescale 1ns/1ps
`include "stl1_consts.svh"

module stl1_cmd_latch
  import stl1_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic frameStrobe,
  input wire logic [WIDTH-1:0] cmdIn,
  output logic [WIDTH-1:0] cmdCode,
  output logic cmdNew
);

  logic [WIDTH-1:0] sample_reg;
  logic sampleValid_reg;
  logic [WIDTH-1:0] cmdCode_reg;
  logic cmdNew_reg;

  // Two equal frames needed: a code changing mid-frame is not acted on
  always_ff @(posedge clk) begin
    if (rst) begin
      sample_reg <= {WIDTH{1'b1}};
      sampleValid_reg <= 1'b0;
    end else if (frameStrobe) begin
      sample_reg <= cmdIn;
      sampleValid_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cmdCode_reg <= {WIDTH{1'b1}};
      cmdNew_reg <= 1'b0;
    end else begin
      cmdNew_reg <= 1'b0;
      if (frameStrobe && sampleValid_reg && cmdIn == sample_reg) begin
        cmdCode_reg <= cmdIn;
        cmdNew_reg <= 1'b1;
      end
    end
  end

  assign cmdCode = cmdCode_reg;
  assign cmdNew = cmdNew_reg;

endmodule

// ### rtl/stl1_act_fsm.sv
`timescale 1ns/1ps
`include "stl1_consts.svh"

// What this block does
// - Deactivation request sends INFO 0, starts deactivation
// - Clear command resets machine, ignores line infos
// - Codes 0010/0011 enter pulse test states
// - Activation request starts exchange side activation
// - Loop activation request closes analog loopback
// - Deactivation confirm enters deactivated, INFO 0 detect
// - Exchange mode reports timing while deactivated
// - Network mode reports timing during deactivation
// - Unsynchronised receiver reports code 0100
// - Terminal wake-up reports activation request in network mode; exchange mode goes to pending activation
// - Code violation reported only when enabled
// - Synchronous receiver reports activation done
// - Done after 16 ms INFO 0 or 32 ms
// - Wait state held until deactivation confirm, clear or pulse test command
// - Deactivated: silent, clocks gated, both activate
// - Network mode: INFO 0 detected, await go
// - Go command sends INFO 2; loop closes loop 2
// - Network mode: after INFO 3, INFO 2 until switch-through; exchange mode goes straight to active
// - Switch-through sends INFO 4, transparent channels
// - Lost sync while active enters lost framing
// - Network mode: upstream unsync command makes device send INFO 2
// - Network mode deactivation accepted from any state except pending deactivation and wait confirm
// - Indication follows current state continuously

module stl1_act_fsm
  import stl1_pkg::*;
#(
  parameter int QUIET_CYC = `STL1_INFO0_QUIET_CYC,
  parameter int DEACT_CYC = `STL1_DEACT_TIMER_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic networkTermMode,
  input wire logic codeViolationEnable,
  input wire logic clockGateOnDeact,
  input wire logic frameStrobe,
  input wire logic [3:0] cmdIn,
  input wire stl1_line_rx_t lineRx,
  output logic [3:0] indOut,
  output stl1_line_ctl_t lineCtl
);

  // ****************************************
  // Command sampling
  // ****************************************
  logic [3:0] cmdCode;
  logic cmdNew;

  stl1_cmd_latch #(.WIDTH(4)) cmdLatch (
    .clk(clk),
    .rst(rst),
    .frameStrobe(frameStrobe),
    .cmdIn(cmdIn),
    .cmdCode(cmdCode),
    .cmdNew(cmdNew)
  );

  // Commands are levels; acting on the held code keeps the controller's
  // repeated code harmless since every transition is idempotent
  logic [3:0] cmd_reg;
  logic cmdValid_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_reg <= `STL1_CMD_DEACT_CONFIRM;
      cmdValid_reg <= 1'b0;
    end else if (cmdNew) begin
      cmd_reg <= cmdCode;
      cmdValid_reg <= 1'b1;
    end
  end

  function automatic logic isCmd(input logic [3:0] c, input logic [3:0] code, input logic v);
    isCmd = v && (c == code);
  endfunction

  function automatic logic isNtCmd(input logic [3:0] c, input logic [3:0] code, input logic v, input logic nt);
    isNtCmd = nt && isCmd(c, code, v);
  endfunction

  // Line decodes used by the state machine and the quiet timer
  function automatic logic lineUp(input stl1_line_rx_t rx);
    lineUp = rx.info3 && rx.sync;
  endfunction

  function automatic logic lineWake(input stl1_line_rx_t rx);
    lineWake = rx.level && !rx.info0;
  endfunction

  function automatic logic lineQuiet(input stl1_line_rx_t rx);
    lineQuiet = rx.info0 && !rx.level;
  endfunction

  // Terminal count for both deactivation timers
  function automatic logic reached(input logic [31:0] cnt, input int limit);
    reached = cnt >= 32'(limit - 1);
  endfunction

  // Violations only matter on a live link, never while cleared
  function automatic logic linkLive(input stl1_state_t s);
    linkLive = s != ST_CLEARED && s != ST_DEACT;
  endfunction

  // ****************************************
  // Deactivation timers
  // ****************************************
  logic [31:0] quietCnt_reg;
  logic [31:0] deactCnt_reg;
  stl1_state_t state_reg;
  stl1_state_t state_next;
  logic quietDone;
  logic deactDone;

  assign quietDone = reached(quietCnt_reg, QUIET_CYC);
  assign deactDone = reached(deactCnt_reg, DEACT_CYC);

  // 32-bit counters cost flops but take any timer override unchanged
  always_ff @(posedge clk) begin
    if (rst || state_reg != ST_PEND_DEACT) begin
      deactCnt_reg <= 32'h0;
    end else begin
      deactCnt_reg <= deactCnt_reg + 32'h1;
    end
  end

  // Quiet time must be continuous: any level restarts it
  always_ff @(posedge clk) begin
    if (rst || state_reg != ST_PEND_DEACT) begin
      quietCnt_reg <= 32'h0;
    end else if (lineQuiet(lineRx)) begin
      quietCnt_reg <= quietCnt_reg + 32'h1;
    end else begin
      quietCnt_reg <= 32'h0;
    end
  end

  // ****************************************
  // State machine
  // ****************************************
  logic cDr;
  logic cClr;
  logic cSsp;
  logic cScp;
  logic cRsy;
  logic cAr;
  logic cArl;
  logic cAi;
  logic cAil;
  logic cDc;
  logic cGo;

  assign cDr = isCmd(cmd_reg, `STL1_CMD_DEACT_REQ, cmdValid_reg);
  assign cClr = isCmd(cmd_reg, `STL1_CMD_CLEAR, cmdValid_reg);
  assign cSsp = isCmd(cmd_reg, `STL1_CMD_SINGLE_PULSE, cmdValid_reg);
  assign cScp = isCmd(cmd_reg, `STL1_CMD_CONT_PULSE, cmdValid_reg);
  assign cRsy = isNtCmd(cmd_reg, `STL1_CMD_RX_UNSYNC, cmdValid_reg, networkTermMode);
  assign cAr = isCmd(cmd_reg, `STL1_CMD_ACT_REQ, cmdValid_reg);
  assign cArl = isCmd(cmd_reg, `STL1_CMD_LOOP_ACT_REQ, cmdValid_reg);
  assign cAi = isNtCmd(cmd_reg, `STL1_CMD_ACT_DONE, cmdValid_reg, networkTermMode);
  assign cAil = isCmd(cmd_reg, `STL1_CMD_LOOP_ACT_IND, cmdValid_reg);
  assign cDc = isCmd(cmd_reg, `STL1_CMD_DEACT_CONFIRM, cmdValid_reg);
  assign cGo = cAr || cArl;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_DEACT: begin
        if (cGo) begin
          state_next = ST_PEND_ACT;
        end else if (lineWake(lineRx)) begin
          // Exchange side starts straight away; network side asks first
          state_next = networkTermMode ? ST_INFO0_DET : ST_PEND_ACT;
        end
      end
      ST_INFO0_DET: begin
        if (cGo) begin
          state_next = ST_PEND_ACT;
        end
      end
      ST_PEND_ACT: begin
        if (lineUp(lineRx)) begin
          state_next = networkTermMode ? ST_WAIT_SWITCH : ST_ACTIVE;
        end
      end
      ST_WAIT_SWITCH: begin
        if (cAi || cAil) begin
          state_next = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (!lineRx.sync) begin
          state_next = ST_LOST_ST;
        end else if (cRsy) begin
          state_next = ST_LOST_UP;
        end
      end
      ST_LOST_ST: begin
        if (lineUp(lineRx)) begin
          state_next = networkTermMode ? ST_WAIT_SWITCH : ST_ACTIVE;
        end
      end
      ST_LOST_UP: begin
        if (cAi || cAil) begin
          state_next = ST_ACTIVE;
        end
      end
      ST_PEND_DEACT: begin
        if (quietDone || deactDone) begin
          state_next = ST_WAIT_CONFIRM;
        end
      end
      ST_WAIT_CONFIRM: begin
        if (cDc) begin
          state_next = ST_DEACT;
        end
      end
      ST_CLEARED, ST_TEST_SINGLE, ST_TEST_CONT: begin
        if (cDc) begin
          state_next = ST_DEACT;
        end
      end
      default: begin
        state_next = ST_DEACT;
      end
    endcase
    // Unconditional commands override the per-state path
    if (cSsp) begin
      state_next = ST_TEST_SINGLE;
    end
    if (cScp) begin
      state_next = ST_TEST_CONT;
    end
    // Exchange side has nothing to tear down while already deactivated
    if (cDr && state_reg != ST_WAIT_CONFIRM && state_reg != ST_PEND_DEACT
        && (networkTermMode || state_reg != ST_DEACT)) begin
      state_next = ST_PEND_DEACT;
    end
    if (cClr) begin
      state_next = ST_CLEARED;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_DEACT;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Line control and indication
  // ****************************************
  stl1_line_ctl_t lineCtl_reg;
  stl1_line_ctl_t lineCtl_next;
  logic [3:0] ind_reg;
  logic [3:0] ind_next;

  always_comb begin
    lineCtl_next = '0;
    lineCtl_next.txInfo = TX_INFO0;
    unique case (state_next)
      ST_PEND_ACT, ST_WAIT_SWITCH, ST_LOST_ST, ST_LOST_UP: begin
        lineCtl_next.txInfo = TX_INFO2;
      end
      ST_ACTIVE: begin
        lineCtl_next.txInfo = TX_INFO4;
        lineCtl_next.transparent = 1'b1;
      end
      ST_TEST_SINGLE: begin
        lineCtl_next.txInfo = TX_SINGLE;
      end
      ST_TEST_CONT: begin
        lineCtl_next.txInfo = TX_CONT;
      end
      ST_DEACT: begin
        lineCtl_next.clockStop = clockGateOnDeact;
      end
      default: begin
        lineCtl_next.txInfo = TX_INFO0;
      end
    endcase
    // Loop 2 follows loop request during pending activation, loop indication while active
    if ((state_next == ST_PEND_ACT && cArl) || (state_next == ST_ACTIVE && cAil)) begin
      lineCtl_next.loop2Closed = 1'b1;
    end
  end

  always_comb begin
    ind_next = `STL1_IND_TIMING;
    unique case (state_next)
      ST_DEACT: begin
        ind_next = networkTermMode ? `STL1_IND_DEACT_DONE : `STL1_IND_TIMING;
      end
      ST_INFO0_DET: begin
        ind_next = `STL1_IND_ACT_REQ;
      end
      ST_PEND_ACT, ST_LOST_ST: begin
        ind_next = lineRx.level ? `STL1_IND_RX_UNSYNC : `STL1_IND_ACT_REQ;
      end
      ST_WAIT_SWITCH, ST_ACTIVE, ST_LOST_UP: begin
        ind_next = lineRx.sync ? `STL1_IND_ACT_DONE : `STL1_IND_RX_UNSYNC;
      end
      ST_PEND_DEACT: begin
        ind_next = `STL1_IND_TIMING;
      end
      ST_WAIT_CONFIRM: begin
        ind_next = `STL1_IND_DEACT_DONE;
      end
      ST_CLEARED: begin
        ind_next = `STL1_IND_CLEAR;
      end
      default: begin
        ind_next = `STL1_IND_TIMING;
      end
    endcase
    if (codeViolationEnable && lineRx.codeViol && linkLive(state_next)) begin
      ind_next = `STL1_IND_CODE_VIOL;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ind_reg <= `STL1_IND_TIMING;
    end else begin
      ind_reg <= ind_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lineCtl_reg <= '0;
    end else begin
      lineCtl_reg <= lineCtl_next;
    end
  end

  assign indOut = ind_reg;
  assign lineCtl = lineCtl_reg;

endmodule

// ### tb/stl1_act_fsm_properties.sv
`timescale 1ns/1ps
module stl1_act_fsm_properties
  import stl1_pkg::*;
#(
  parameter int QUIET_CYC = 20,
  parameter int DEACT_CYC = 40
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic networkTermMode,
  input wire logic codeViolationEnable,
  input wire logic clockGateOnDeact,
  input wire logic frameStrobe,
  input wire logic [3:0] cmdIn,
  input wire stl1_line_rx_t lineRx,
  input wire logic [3:0] indOut,
  input wire stl1_line_ctl_t lineCtl
);
  // ****
  // Helpers
  // ****
  logic [3:0] sample_reg;
  logic have_reg;
  logic [1:0] hist_reg;
  int pend_reg;
  int quiet_reg;
  logic acc;
  logic pending;
  // Only post-reset samples count, so an early accept never fires a check
  assign acc = frameStrobe && have_reg && cmdIn == sample_reg;
  assign pending = networkTermMode && lineCtl.txInfo == TX_INFO0 && indOut == 4'h0;

  always_ff @(posedge clk) begin
    if (rst) begin
      have_reg <= 1'b0;
      sample_reg <= 4'h0;
    end else if (frameStrobe) begin
      have_reg <= 1'b1;
      sample_reg <= cmdIn;
    end
  end

  always_ff @(posedge clk) begin
    hist_reg <= rst ? 2'h0 : {hist_reg[0], acc};
  end

  always_ff @(posedge clk) begin
    pend_reg <= (rst || !pending) ? 0 : pend_reg + 1;
    quiet_reg <= (rst || !pending || !lineRx.info0) ? 0 : quiet_reg + 1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_take(logic [3:0] c);
    acc && cmdIn == c;
  endsequence

  // ****
  // Properties
  // ****
  a_clear_info0: assert property (s_take(4'h1) |-> ##3 lineCtl.txInfo == TX_INFO0 && indOut == 4'h1)
    else $error("clear did not reach idle line");
  a_deact_info0: assert property (networkTermMode and s_take(4'h0) |-> ##3 lineCtl.txInfo == TX_INFO0)
    else $error("deactivation request ignored");
  a_test_single: assert property (s_take(4'h2) |-> ##3 lineCtl.txInfo == TX_SINGLE)
    else $error("single pulse test missing");
  a_test_cont: assert property (s_take(4'h3) |-> ##3 lineCtl.txInfo == TX_CONT)
    else $error("continuous pulse test missing");
  a_confirm_deact: assert property ((!networkTermMode && indOut == 4'hF && !lineRx.level) and s_take(4'hF)
    |-> ##3 indOut == 4'h0 && lineCtl.txInfo == TX_INFO0 && lineCtl.clockStop == clockGateOnDeact)
    else $error("confirm did not deactivate");
  a_deact_timer: assert property (pend_reg <= DEACT_CYC + 3)
    else $error("deactivation timer overran");
  a_quiet_bound: assert property (quiet_reg <= QUIET_CYC + 3)
    else $error("quiet line not detected");
  a_wait_holds: assert property (!networkTermMode && indOut == 4'hF && !codeViolationEnable
    && !$past(codeViolationEnable) && !acc && hist_reg == 2'h0 |=> indOut == 4'hF)
    else $error("wait state left without confirm");
  a_transp_info4: assert property (lineCtl.transparent |-> lineCtl.txInfo == TX_INFO4)
    else $error("transparent without INFO 4");
  a_gate_silent: assert property (lineCtl.clockStop |-> lineCtl.txInfo == TX_INFO0)
    else $error("clocks stopped while sending");
  a_viol_gated: assert property (!codeViolationEnable [*3] |-> indOut != 4'hB)
    else $error("violation shown while disabled");
endmodule

bind stl1_act_fsm stl1_act_fsm_properties #(.QUIET_CYC(QUIET_CYC), .DEACT_CYC(DEACT_CYC)) props (
  .clk(clk), .rst(rst), .networkTermMode(networkTermMode), .codeViolationEnable(codeViolationEnable),
  .clockGateOnDeact(clockGateOnDeact), .frameStrobe(frameStrobe), .cmdIn(cmdIn), .lineRx(lineRx),
  .indOut(indOut), .lineCtl(lineCtl));

// ### tb/stl1_terminal_model.sv
`timescale 1ns/1ps
module stl1_terminal_model
  import stl1_pkg::*;
#(
  parameter int LAG = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire stl1_line_ctl_t lineCtl,
  input wire logic wake,
  input wire logic dropSync,
  input wire logic badCode,
  output stl1_line_rx_t lineRx
);
  stl1_tx_info_t heard_reg;
  int lag_reg;
  // Slow receiver: a new info is heard only after LAG+1 cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      heard_reg <= TX_INFO0;
      lag_reg <= 0;
    end else if (lineCtl.txInfo != heard_reg && lag_reg < LAG) begin
      lag_reg <= lag_reg + 1;
    end else begin
      heard_reg <= lineCtl.txInfo;
      lag_reg <= 0;
    end
  end

  always_comb begin
    lineRx = '0;
    lineRx.codeViol = badCode;
    if (heard_reg == TX_INFO2 || heard_reg == TX_INFO4) begin
      lineRx.level = 1'b1;
      lineRx.info3 = 1'b1;
      lineRx.sync = !dropSync;
    end else if (wake) begin
      lineRx.level = 1'b1;
    end else begin
      lineRx.info0 = 1'b1;
    end
  end
endmodule

// ### tb/stl1_act_fsm_tb.sv
`timescale 1ns/1ps
module stl1_act_fsm_tb
  import stl1_pkg::*;
;
  localparam int QC = 20;
  localparam int DC = 40;
  logic clk, rst, networkTermMode, codeViolationEnable, clockGateOnDeact;
  logic frameStrobe = 1'b0;
  logic [3:0] cmdIn, indOut;
  logic wake, dropSync, badCode;
  int failures, samples_checked;
  int phase = 0;
  stl1_line_rx_t lineRx;
  stl1_line_ctl_t lineCtl;

  stl1_act_fsm #(.QUIET_CYC(QC), .DEACT_CYC(DC)) DUT (.clk(clk), .rst(rst), .networkTermMode(networkTermMode),
    .codeViolationEnable(codeViolationEnable), .clockGateOnDeact(clockGateOnDeact), .frameStrobe(frameStrobe),
    .cmdIn(cmdIn), .lineRx(lineRx), .indOut(indOut), .lineCtl(lineCtl));
  stl1_terminal_model #(.LAG(3)) term (.clk(clk), .rst(rst), .lineCtl(lineCtl), .wake(wake),
    .dropSync(dropSync), .badCode(badCode), .lineRx(lineRx));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Frame strobe every 8 cycles
  always @(negedge clk) begin
    phase <= (phase == 7) ? 0 : phase + 1;
    frameStrobe <= (phase == 7);
  end

  // ****
  // Helpers
  // ****
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic send(input logic [3:0] c);
    cmdIn = c;
    repeat (2) @(posedge frameStrobe);
    cyc(4);
  endtask
  task automatic doReset(input logic nt);
    rst = 1'b1;
    networkTermMode = nt;
    cyc(6);
    rst = 1'b0;
    cyc(2);
  endtask
  task automatic judge(input logic ok, input string what);
    samples_checked++;
    if (ok !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic chkInd(input logic [3:0] exp);
    judge(indOut === exp, "indication");
  endtask
  task automatic chkTx(input stl1_tx_info_t exp);
    judge(lineCtl.txInfo === exp, "line info");
  endtask
  task automatic chkBit(input logic got, input logic exp);
    judge(got === exp, "line control flag");
  endtask
  task automatic summarize();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ****
  // Scenarios
  // ****
  task automatic lt_activation();
    chkInd(4'h0);
    send(4'h8);
    chkTx(TX_INFO2);
    cyc(20);
    chkTx(TX_INFO4);
    chkInd(4'hC);
  endtask
  task automatic lt_faults();
    badCode = 1'b1;
    cyc(6);
    chkInd(4'hC);
    codeViolationEnable = 1'b1;
    cyc(6);
    chkInd(4'hB);
    codeViolationEnable = 1'b0;
    badCode = 1'b0;
    dropSync = 1'b1;
    cyc(10);
    chkTx(TX_INFO2);
    chkInd(4'h4);
    dropSync = 1'b0;
  endtask
  task automatic lt_deactivation();
    wake = 1'b1;
    send(4'h0);
    chkTx(TX_INFO0);
    cyc(50);
    chkInd(4'hF);
    cyc(100);
    chkInd(4'hF);
    wake = 1'b0;
    cyc(8);
    send(4'hF);
    chkInd(4'h0);
    chkBit(lineCtl.clockStop, 1'b1);
    send(4'hA);
    chkBit(lineCtl.loop2Closed, 1'b1);
  endtask
  task automatic nt_activation();
    chkInd(4'hF);
    wake = 1'b1;
    cyc(10);
    chkInd(4'h8);
    chkTx(TX_INFO0);
    send(4'h8);
    chkTx(TX_INFO2);
    cyc(20);
    chkTx(TX_INFO2);
    chkBit(lineCtl.transparent, 1'b0);
    send(4'hC);
    chkBit(lineCtl.transparent, 1'b1);
    send(4'h4);
    chkTx(TX_INFO2);
    send(4'hC);
    chkTx(TX_INFO4);
    send(4'hE);
    chkBit(lineCtl.loop2Closed, 1'b1);
  endtask
  task automatic nt_deactivation();
    wake = 1'b0;
    send(4'h0);
    chkTx(TX_INFO0);
    chkInd(4'h0);
    cyc(30);
    chkInd(4'hF);
    send(4'hF);
    chkBit(lineCtl.clockStop, 1'b1);
  endtask
  task automatic nt_clear_tests();
    send(4'h1);
    chkTx(TX_INFO0);
    wake = 1'b1;
    cyc(10);
    chkInd(4'h1);
    send(4'h2);
    chkTx(TX_SINGLE);
    send(4'h3);
    chkTx(TX_CONT);
    wake = 1'b0;
    send(4'hF);
    chkTx(TX_INFO0);
  endtask

  initial begin
    rst = 1'b1;
    networkTermMode = 1'b0;
    codeViolationEnable = 1'b0;
    clockGateOnDeact = 1'b1;
    cmdIn = 4'h6;
    wake = 1'b0;
    dropSync = 1'b0;
    badCode = 1'b0;
    failures = 0;
    samples_checked = 0;
    doReset(1'b0);
    lt_activation();
    lt_faults();
    lt_deactivation();
    cmdIn = 4'h6;
    doReset(1'b1);
    nt_activation();
    nt_deactivation();
    nt_clear_tests();
    summarize();
  end

  // Whole run is near 520 cycles; cut off well beyond it
  initial begin
    #100us;
    failures++;
    summarize();
  end
endmodule
